// ===== design/bssq_boot_sequencer.sv
// Start-up boot sequencer: non-volatile boot or serial scan boot.
module bssq_boot_sequencer
    import bssq_pkg::*;
#(
    parameter logic [31:0] STEP_TIMEOUT = 32'(STEP_TIMEOUT_CYC)
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Header from the one-time-programmable store
    input  wire logic        hdrValid,
    input  wire bssq_hdr_t   hdr,
    input  wire logic [31:0] pinPresent,
    // Memory-system command handshake
    input  wire logic        memDone,
    input  wire logic [15:0] flashMagic,
    // Fast crystal status
    input  wire logic        xtalReady,
    // Serial loader feedback, from a pin-domain engine
    input  wire logic        hostSeen,
    input  wire logic        loadDone,
    // Memory commands
    output bssq_mem_t        memCmd,
    output logic             memStart,
    output logic             cacheBypass,
    output bssq_remap_t      remapSel,
    output logic             softReset,
    // Clock control
    output logic             fastClockSel,
    // Serial link control
    output bssq_link_t       linkCfg,
    output logic             linkEnable,
    output logic [3:0]       scanStep,
    // Status
    output logic             bootIdle,
    output logic             bootFailed
);

    typedef enum logic [4:0] {
        ST_WAIT_HDR,
        ST_FL_RESET,
        ST_FL_INIT,
        ST_FL_MAGIC,
        ST_UCODE,
        ST_COPY_IMAGE,
        ST_CACHE_INIT,
        ST_COPY_VEC,
        ST_REMAP,
        ST_SOFT_RESET,
        ST_XTAL,
        ST_FIXED,
        ST_SCAN_PICK,
        ST_SCAN_LISTEN,
        ST_LOADING,
        ST_PROBE_RESET,
        ST_PROBE_INIT,
        ST_PROBE_MAGIC,
        ST_DONE,
        ST_IDLE
    } bssq_state_t;

    bssq_state_t state_reg;
    bssq_state_t state_next;

    // Two-stage synchronisers for pin-derived inputs.
    logic [1:0] hostSync_reg;
    logic [1:0] loadSync_reg;
    logic [1:0] xtalSync_reg;
    logic       hostSeen_s;
    logic       loadDone_s;
    logic       xtalReady_s;

    logic [3:0] step_reg;
    logic       cmdIssued_reg;
    logic       probeMode_reg;
    bssq_link_t tableLink;
    logic       tableUsable;
    logic       timerRestart;
    logic       timerExpired;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hostSync_reg <= 2'h0;
            loadSync_reg <= 2'h0;
            xtalSync_reg <= 2'h0;
        end
        else
        begin
            hostSync_reg <= {hostSync_reg[0], hostSeen};
            loadSync_reg <= {loadSync_reg[0], loadDone};
            xtalSync_reg <= {xtalSync_reg[0], xtalReady};
        end
    end

    assign hostSeen_s  = hostSync_reg[1];
    assign loadDone_s  = loadSync_reg[1];
    assign xtalReady_s = xtalSync_reg[1];

    bssq_scan_table u_table (
        .step       (step_reg),
        .pinPresent (pinPresent),
        .link       (tableLink),
        .usable     (tableUsable)
    );

    bssq_step_timer #(
        .TIMEOUT (STEP_TIMEOUT)
    ) u_timer (
        .clk     (clk),
        .srst    (srst),
        .restart (timerRestart),
        .run     (state_reg == ST_SCAN_LISTEN),
        .expired (timerExpired)
    );

    assign timerRestart = (state_reg == ST_SCAN_PICK);

    // Memory steps share one handshake: a start pulse, then wait for done.
    function automatic logic memStep(input logic issued, input logic done);
        return issued && done;
    endfunction

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_WAIT_HDR:
                if (hdrValid)
                begin
                    if (hdr.deployed)
                        state_next = hdr.flashSource ? ST_FL_RESET : ST_UCODE;
                    else
                        state_next = ST_XTAL;
                end
            ST_FL_RESET:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_FL_INIT;
            ST_FL_INIT:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_FL_MAGIC;
            ST_FL_MAGIC:
                if (memStep(cmdIssued_reg, memDone))
                    state_next = (flashMagic == MAGIC_WORD) ? ST_UCODE : ST_IDLE;
            ST_UCODE:
                // The probe after a failed scan boots from flash, so it needs the microcode too.
                if (!hdr.flashSource && !probeMode_reg)
                    state_next = hdr.cacheMode ? ST_COPY_VEC : ST_COPY_IMAGE;
                else if (memStep(cmdIssued_reg, memDone))
                    state_next = hdr.cacheMode ? ST_CACHE_INIT : ST_COPY_IMAGE;
            ST_COPY_IMAGE:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_REMAP;
            ST_CACHE_INIT:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_COPY_VEC;
            ST_COPY_VEC:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_REMAP;
            ST_REMAP:
                state_next = ST_SOFT_RESET;
            ST_SOFT_RESET:
                state_next = ST_DONE;
            ST_XTAL:
                if (xtalReady_s)
                    state_next = hdr.serialFixed ? ST_FIXED : ST_SCAN_PICK;
            ST_FIXED:
                if (loadDone_s) state_next = ST_DONE;
            ST_SCAN_PICK:
                if (step_reg > LAST_STEP) state_next = ST_PROBE_RESET;
                else if (tableUsable) state_next = ST_SCAN_LISTEN;
            ST_SCAN_LISTEN:
                if (hostSeen_s) state_next = ST_LOADING;
                else if (timerExpired) state_next = ST_SCAN_PICK;
            ST_LOADING:
                if (loadDone_s) state_next = ST_DONE;
            ST_PROBE_RESET:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_PROBE_INIT;
            ST_PROBE_INIT:
                if (memStep(cmdIssued_reg, memDone)) state_next = ST_PROBE_MAGIC;
            ST_PROBE_MAGIC:
                if (memStep(cmdIssued_reg, memDone))
                    state_next = (flashMagic == MAGIC_WORD) ? ST_UCODE : ST_IDLE;
            ST_DONE:
                state_next = ST_DONE;
            ST_IDLE:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_reg <= ST_WAIT_HDR;
        else
            state_reg <= state_next;
    end

    // Step counter only climbs, so each step is tried at most once.
    always_ff @(posedge clk)
    begin
        if (srst)
            step_reg <= 4'h0;
        else if (state_reg == ST_SCAN_PICK && !tableUsable && step_reg <= LAST_STEP)
            step_reg <= step_reg + 4'h1;
        else if (state_reg == ST_SCAN_LISTEN && !hostSeen_s && timerExpired)
            step_reg <= step_reg + 4'h1;
    end

    // The probe after a failed scan reuses the flash source path.
    always_ff @(posedge clk)
    begin
        if (srst)
            probeMode_reg <= 1'b0;
        else if (state_reg == ST_PROBE_RESET)
            probeMode_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst || state_reg != state_next)
            cmdIssued_reg <= 1'b0;
        else if (memStart)
            cmdIssued_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            memCmd   <= MEM_NONE;
            memStart <= 1'b0;
        end
        else
        begin
            memStart <= 1'b0;
            memCmd   <= MEM_NONE;
            if (!cmdIssued_reg && !memStart && state_reg == state_next)
            begin
                memStart <= 1'b1;
                unique case (state_reg)
                    ST_FL_RESET, ST_PROBE_RESET: memCmd <= MEM_FLASH_RESET;
                    ST_FL_INIT, ST_PROBE_INIT:   memCmd <= MEM_FLASH_INIT;
                    ST_FL_MAGIC, ST_PROBE_MAGIC: memCmd <= MEM_FLASH_INIT;
                    ST_UCODE:                    memCmd <= MEM_LOAD_UCODE;
                    ST_COPY_IMAGE:               memCmd <= MEM_COPY_IMAGE;
                    ST_CACHE_INIT:               memCmd <= MEM_CACHE_INIT;
                    ST_COPY_VEC:                 memCmd <= MEM_COPY_VECTORS;
                    default:                     memStart <= 1'b0;
                endcase
            end
            // The command stays from its start pulse until the state moves on.
            else if (cmdIssued_reg || memStart)
                memCmd <= memCmd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cacheBypass <= 1'b0;
            remapSel    <= REMAP_ROM;
            softReset   <= 1'b0;
        end
        else
        begin
            softReset <= (state_reg == ST_SOFT_RESET);
            if (state_reg == ST_COPY_IMAGE)
                cacheBypass <= 1'b1;
            if (state_reg == ST_REMAP)
                remapSel <= (hdr.flashSource || probeMode_reg) ? REMAP_FLASH : REMAP_OTP;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            fastClockSel <= 1'b0;
        else if (state_reg == ST_XTAL)
            fastClockSel <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            linkCfg    <= '{IF_NONE, P0_0, P0_0, P0_0, P0_0, DIV_MASTER};
            linkEnable <= 1'b0;
            scanStep   <= 4'h0;
        end
        else
        begin
            scanStep <= step_reg;
            if (state_reg == ST_FIXED)
            begin
                linkCfg    <= hdr.fixedLink;
                linkEnable <= 1'b1;
            end
            else if (state_reg == ST_SCAN_LISTEN || state_reg == ST_LOADING)
            begin
                linkCfg    <= tableLink;
                linkEnable <= 1'b1;
            end
            else
                linkEnable <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bootIdle   <= 1'b0;
            bootFailed <= 1'b0;
        end
        else
        begin
            bootIdle   <= (state_reg == ST_DONE) || (state_reg == ST_IDLE);
            bootFailed <= (state_reg == ST_IDLE);
        end
    end

endmodule

// ===== design/bssq_pkg.sv
// Package with constants, enumerations and carriers for the boot sequencer.
package bssq_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;

    // Flash magic word, ASCII "qQ".
    localparam logic [15:0] MAGIC_WORD = 16'h7151;

    // Serial rates of the scan steps.
    localparam int unsigned UART_FAST_BPS = 115_200;
    localparam int unsigned UART_SLOW_BPS = 57_600;
    localparam int unsigned SPI_SLAVE_HZ  = 2_000_000;
    localparam int unsigned I2C_FAST_BPS  = 400_000;
    localparam int unsigned I2C_SLOW_BPS  = 100_000;

    // Clock divisors, derived from the rates (rounded down), except DIV_MASTER, which is 0.
    localparam logic [15:0] DIV_UART_FAST = 16'(CLK_HZ / UART_FAST_BPS);
    localparam logic [15:0] DIV_UART_SLOW = 16'(CLK_HZ / UART_SLOW_BPS);
    localparam logic [15:0] DIV_SPI_SLAVE = 16'(CLK_HZ / SPI_SLAVE_HZ);
    localparam logic [15:0] DIV_I2C_FAST  = 16'(CLK_HZ / I2C_FAST_BPS);
    localparam logic [15:0] DIV_I2C_SLOW  = 16'(CLK_HZ / I2C_SLOW_BPS);
    localparam logic [15:0] DIV_MASTER    = 16'h0000;

    // Per-step listening window.
    localparam int unsigned STEP_TIMEOUT_MS   = 100;
    localparam int unsigned STEP_TIMEOUT_CYC  = CLK_HZ / 1000 * STEP_TIMEOUT_MS;

    localparam int unsigned NUM_STEPS  = 11;
    localparam logic [3:0]  LAST_STEP  = 4'hA;

    // Pin numbers: port * 8 + bit.
    localparam logic [4:0] P0_0 = 5'h00;
    localparam logic [4:0] P0_1 = 5'h01;
    localparam logic [4:0] P0_2 = 5'h02;
    localparam logic [4:0] P0_3 = 5'h03;
    localparam logic [4:0] P0_4 = 5'h04;
    localparam logic [4:0] P0_5 = 5'h05;
    localparam logic [4:0] P1_0 = 5'h08;
    localparam logic [4:0] P1_2 = 5'h0A;
    localparam logic [4:0] P1_3 = 5'h0B;
    localparam logic [4:0] P1_4 = 5'h0C;
    localparam logic [4:0] P1_5 = 5'h0D;
    localparam logic [4:0] P2_3 = 5'h13;

    typedef enum logic [2:0] {
        IF_NONE,
        IF_SPI_MASTER,
        IF_UART,
        IF_SPI_SLAVE,
        IF_I2C
    } bssq_ifc_t;

    // One serial link configuration: interface, pins and clock divisor.
    typedef struct packed {
        bssq_ifc_t  ifc;
        logic [4:0] pinA;
        logic [4:0] pinB;
        logic [4:0] pinC;
        logic [4:0] pinD;
        logic [15:0] divisor;
    } bssq_link_t;

    // Header fields as read from the one-time-programmable store.
    typedef struct packed {
        logic       deployed;
        logic       flashSource;
        logic       cacheMode;
        logic       serialFixed;
        bssq_link_t fixedLink;
    } bssq_hdr_t;

    // Memory-preparation commands to the memory system.
    typedef enum logic [2:0] {
        MEM_NONE,
        MEM_FLASH_RESET,
        MEM_FLASH_INIT,
        MEM_LOAD_UCODE,
        MEM_COPY_IMAGE,
        MEM_CACHE_INIT,
        MEM_COPY_VECTORS
    } bssq_mem_t;

    typedef enum logic [1:0] {
        REMAP_ROM,
        REMAP_FLASH,
        REMAP_OTP
    } bssq_remap_t;

    function automatic logic [31:0] stepTimeout();
        return 32'(STEP_TIMEOUT_CYC);
    endfunction

endpackage

// ===== design/bssq_scan_table.sv
// Fixed serial scan step table with pin-availability skip.
module bssq_scan_table
    import bssq_pkg::*;
(
    // Step select
    input  wire logic [3:0]  step,
    input  wire logic [31:0] pinPresent,
    // Step description
    output bssq_link_t       link,
    output logic             usable
);

    function automatic logic pinsOk(input bssq_link_t l, input logic [31:0] pres);
        logic ok;
        ok = pres[l.pinA] & pres[l.pinB];
        if (l.ifc == IF_SPI_MASTER || l.ifc == IF_SPI_SLAVE)
        begin
            ok = ok & pres[l.pinC] & pres[l.pinD];
        end
        return ok;
    endfunction

    always_comb
    begin
        unique case (step)
            4'h0: link = '{IF_SPI_MASTER, P0_1, P0_2, P0_3, P0_4, DIV_MASTER};
            4'h1: link = '{IF_UART, P0_1, P0_2, P0_0, P0_0, DIV_UART_FAST};
            4'h2: link = '{IF_UART, P0_5, P0_3, P0_0, P0_0, DIV_UART_SLOW};
            4'h3: link = '{IF_UART, P1_0, P1_5, P0_0, P0_0, DIV_UART_SLOW};
            4'h4: link = '{IF_UART, P1_2, P1_4, P0_0, P0_0, DIV_UART_SLOW};
            4'h5: link = '{IF_UART, P1_3, P2_3, P0_0, P0_0, DIV_UART_SLOW};
            4'h6: link = '{IF_SPI_SLAVE, P0_2, P0_1, P0_0, P0_5, DIV_SPI_SLAVE};
            4'h7: link = '{IF_I2C, P0_1, P0_2, P0_0, P0_0, DIV_I2C_FAST};
            4'h8: link = '{IF_I2C, P0_5, P0_3, P0_0, P0_0, DIV_I2C_FAST};
            4'h9: link = '{IF_I2C, P1_0, P1_5, P0_0, P0_0, DIV_I2C_SLOW};
            4'hA: link = '{IF_I2C, P1_3, P2_3, P0_0, P0_0, DIV_I2C_SLOW};
            default: link = '{IF_NONE, P0_0, P0_0, P0_0, P0_0, DIV_MASTER};
        endcase
        // A step needs all its pins bonded out on this package variant.
        usable = (link.ifc != IF_NONE) && pinsOk(link, pinPresent);
    end

endmodule

// ===== design/bssq_step_timer.sv
// Listening-window timer for one scan step.
module bssq_step_timer
    import bssq_pkg::*;
#(
    parameter logic [31:0] TIMEOUT = 32'(STEP_TIMEOUT_CYC)
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control
    input  wire logic restart,
    input  wire logic run,
    // Status
    output logic      expired
);

    logic [31:0] count_reg;

    always_ff @(posedge clk)
    begin
        if (srst || restart)
        begin
            count_reg <= 32'h00000000;
            expired   <= 1'b0;
        end
        else if (run && !expired)
        begin
            count_reg <= count_reg + 32'h00000001;
            expired   <= (count_reg + 32'h00000001) >= TIMEOUT;
        end
    end

endmodule

// ===== sim/bssq_mem_model.sv
// Memory-system model that answers the sequencer's command handshake.
module bssq_mem_model
    import bssq_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Command handshake
    input  wire logic        memStart,
    input  wire bssq_mem_t   memCmd,
    output logic             memDone,
    output logic [15:0]      flashMagic,
    // Test controls
    input  wire logic        slow,
    input  wire logic [15:0] magicVal
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] waitCnt = 4'h0;
    logic       busy = 1'b0;

    initial
    begin
        memDone = 1'b0;
        flashMagic = 16'h0000;
    end

    // Outside its answer cycle the magic bus toggles, so a stale value is never mistaken for data.
    always @(posedge clk)
    begin
        memDone <= 1'b0;
        flashMagic <= ~flashMagic;
        if (memStart)
        begin
            busy <= 1'b1;
            waitCnt <= slow ? 4'h7 : 4'h0;
        end
        else if (busy && waitCnt != 4'h0)
            waitCnt <= waitCnt - 4'h1;
        else if (busy)
        begin
            busy <= 1'b0;
            memDone <= 1'b1;
            flashMagic <= (memCmd == MEM_FLASH_INIT) ? magicVal : ~magicVal;
        end
    end
endmodule

// ===== sim/bssq_boot_sequencer_assertions.sv
// Port checker for the boot sequencer, bound to its top module.
module bssq_boot_sequencer_checker
    import bssq_pkg::*;
#(
    parameter logic [31:0] STEP_TIMEOUT = 32'(STEP_TIMEOUT_CYC)
)
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Design inputs
    input wire logic        hdrValid,
    input wire bssq_hdr_t   hdr,
    input wire logic [31:0] pinPresent,
    input wire logic        memDone,
    input wire logic [15:0] flashMagic,
    input wire logic        xtalReady,
    input wire logic        hostSeen,
    input wire logic        loadDone,
    // Design outputs
    input wire bssq_mem_t   memCmd,
    input wire logic        memStart,
    input wire logic        cacheBypass,
    input wire bssq_remap_t remapSel,
    input wire logic        softReset,
    input wire logic        fastClockSel,
    input wire bssq_link_t  linkCfg,
    input wire logic        linkEnable,
    input wire logic [3:0]  scanStep,
    input wire logic        bootIdle,
    input wire logic        bootFailed
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    function automatic logic [15:0] stepDiv(input logic [3:0] s);
        if (s == 4'h0)
            return DIV_MASTER;
        if (s == 4'h1)
            return DIV_UART_FAST;
        if (s <= 4'h5)
            return DIV_UART_SLOW;
        if (s == 4'h6)
            return DIV_SPI_SLAVE;
        return (s <= 4'h8) ? DIV_I2C_FAST : DIV_I2C_SLOW;
    endfunction

    a_cmd_held: assert property (memStart |=> !memStart && $stable(memCmd))
        else $error("memory command not held after its start pulse");
    a_copy_bypass: assert property (memStart && memCmd == MEM_COPY_IMAGE |-> cacheBypass)
        else $error("image copy started without cache bypass");
    a_cache_direct: assert property (memStart && memCmd == MEM_CACHE_INIT |-> !cacheBypass)
        else $error("cache set up while bypassed");
    a_otp_prep: assert property (memStart && hdr.deployed && !hdr.flashSource
        |-> memCmd == (hdr.cacheMode ? MEM_COPY_VECTORS : MEM_COPY_IMAGE))
        else $error("wrong preparation for the otp source");
    a_reset_remap: assert property (softReset |-> remapSel != REMAP_ROM ##1 !softReset)
        else $error("software reset without remap or not a pulse");
    a_remap_source: assert property (softReset && hdr.deployed
        |-> remapSel == (hdr.flashSource ? REMAP_FLASH : REMAP_OTP))
        else $error("address zero remapped to the wrong store");
    a_clock_first: assert property (linkEnable |-> fastClockSel)
        else $error("serial link enabled on the slow clock");
    a_step_order: assert property ($changed(scanStep) |-> scanStep == $past(scanStep) + 4'h1 || scanStep == 4'h0)
        else $error("scan step out of order");
    a_step_rate: assert property (linkEnable && !hdr.serialFixed |-> linkCfg.divisor == stepDiv(scanStep))
        else $error("scan step uses the wrong rate");
    a_fixed_link: assert property (linkEnable && hdr.serialFixed |-> linkCfg == hdr.fixedLink)
        else $error("fixed link differs from the header");
    a_fail_idle: assert property (bootFailed |-> bootIdle && !linkEnable && !softReset)
        else $error("failed boot is not idle");

    c_soft_reset: cover property (softReset);
    c_boot_failed: cover property ($rose(bootFailed));
    c_last_step: cover property (linkEnable && scanStep == LAST_STEP);
endmodule

bind bssq_boot_sequencer bssq_boot_sequencer_checker #(.STEP_TIMEOUT(STEP_TIMEOUT)) uChk (
    .clk(clk), .srst(srst), .hdrValid(hdrValid), .hdr(hdr), .pinPresent(pinPresent), .memDone(memDone),
    .flashMagic(flashMagic), .xtalReady(xtalReady), .hostSeen(hostSeen), .loadDone(loadDone),
    .memCmd(memCmd), .memStart(memStart), .cacheBypass(cacheBypass), .remapSel(remapSel),
    .softReset(softReset), .fastClockSel(fastClockSel), .linkCfg(linkCfg), .linkEnable(linkEnable),
    .scanStep(scanStep), .bootIdle(bootIdle), .bootFailed(bootFailed)
);

// ===== sim/bssq_boot_sequencer_test.sv
// Self-checking testbench for the boot sequencer.
module bssq_boot_sequencer_test
    import bssq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // A short listening window keeps the full scan to a few hundred cycles.
    localparam logic [31:0] STEP_TO = 32'h14;

    logic        clk = 1'b0, srst = 1'b1, hdrValid = 1'b0, xtalReady = 1'b1;
    logic        hostSeen = 1'b0, loadDone = 1'b0, slow = 1'b0, linkPrev = 1'b0;
    logic        memDone, memStart, cacheBypass, softReset, fastClockSel, linkEnable, bootIdle, bootFailed;
    logic [31:0] pinPresent = 32'hFFFFFFFF;
    logic [15:0] magicVal = MAGIC_WORD;
    logic [15:0] flashMagic;
    logic [3:0]  scanStep, stepPrev = 4'h0;
    bssq_hdr_t   hdr = '0;
    bssq_mem_t   memCmd;
    bssq_remap_t remapSel;
    bssq_link_t  linkCfg;
    int          errorCnt = 0, checks = 0, cyc = 0;
    bssq_mem_t   cmdQ[$];
    logic [3:0]  stepQ[$];
    bssq_ifc_t   expIfc[11] = '{IF_SPI_MASTER, IF_UART, IF_UART, IF_UART, IF_UART, IF_UART, IF_SPI_SLAVE,
                               IF_I2C, IF_I2C, IF_I2C, IF_I2C};

    bssq_boot_sequencer #(.STEP_TIMEOUT(STEP_TO)) DUT (
        .clk(clk), .srst(srst), .hdrValid(hdrValid), .hdr(hdr), .pinPresent(pinPresent), .memDone(memDone),
        .flashMagic(flashMagic), .xtalReady(xtalReady), .hostSeen(hostSeen), .loadDone(loadDone),
        .memCmd(memCmd), .memStart(memStart), .cacheBypass(cacheBypass), .remapSel(remapSel),
        .softReset(softReset), .fastClockSel(fastClockSel), .linkCfg(linkCfg), .linkEnable(linkEnable),
        .scanStep(scanStep), .bootIdle(bootIdle), .bootFailed(bootFailed)
    );

    bssq_mem_model mem (
        .clk(clk), .memStart(memStart), .memCmd(memCmd), .memDone(memDone), .flashMagic(flashMagic),
        .slow(slow), .magicVal(magicVal)
    );

    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic closeOut();
        $display("Comparisons %0d, mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Log every command start and every listening window the sequencer opens.
    always @(posedge clk)
    begin
        cyc++;
        if (memStart === 1'b1)
            cmdQ.push_back(memCmd);
        if (linkEnable === 1'b1 && (!linkPrev || scanStep != stepPrev))
        begin
            stepQ.push_back(scanStep);
            if (!hdr.serialFixed && scanStep <= LAST_STEP)
                check(linkCfg.ifc, expIfc[scanStep]);
        end
        linkPrev = linkEnable;
        stepPrev = scanStep;
        if (cyc == 20000)
        begin
            errorCnt++;
            closeOut();
        end
    end

    task automatic boot(input bssq_hdr_t h, input logic s);
        @(posedge clk);
        srst <= 1'b1;
        hdrValid <= 1'b0;
        hostSeen <= 1'b0;
        loadDone <= 1'b0;
        hdr <= h;
        slow <= s;
        repeat (2) @(posedge clk);
        cmdQ.delete();
        stepQ.delete();
        srst <= 1'b0;
        @(posedge clk);
        hdrValid <= 1'b1;
    endtask

    task automatic waitEnd();
        int n;
        n = 0;
        while (softReset !== 1'b1 && bootFailed !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n < 3000, 1'b1);
    endtask

    task automatic cmpCmds(input bssq_mem_t exp[$]);
        check(cmdQ.size(), exp.size());
        foreach (exp[i])
            if (i < cmdQ.size())
                check(cmdQ[i], exp[i]);
    endtask

    initial
    begin
        bssq_mem_t exp[$];
        repeat (10) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            boot('{1'b1, i[1], i[0], 1'b0, '0}, i[0]);
            waitEnd();
            exp.delete();
            if (i[1])
                exp = '{MEM_FLASH_RESET, MEM_FLASH_INIT, MEM_FLASH_INIT, MEM_LOAD_UCODE};
            if (i[0] && i[1])
                exp.push_back(MEM_CACHE_INIT);
            exp.push_back(i[0] ? MEM_COPY_VECTORS : MEM_COPY_IMAGE);
            cmpCmds(exp);
            check(softReset, 1'b1);
            check(remapSel, i[1] ? REMAP_FLASH : REMAP_OTP);
            check(cacheBypass, !i[0]);
        end
        // Swapped bytes of the magic word must not pass as a bootable flash.
        magicVal <= {MAGIC_WORD[7:0], MAGIC_WORD[15:8]};
        boot('{1'b1, 1'b1, 1'b1, 1'b0, '0}, 1'b0);
        waitEnd();
        check(bootFailed, 1'b1);
        check(cmdQ.size(), 3);
        @(posedge clk);
        pinPresent <= 32'hFFFFFFFF ^ (32'h1 << P2_3);
        xtalReady <= 1'b0;
        boot('{1'b0, 1'b0, 1'b0, 1'b0, '0}, 1'b0);
        repeat (40) @(posedge clk);
        #1;
        check(stepQ.size(), 0);
        check(fastClockSel, 1'b1);
        @(posedge clk);
        xtalReady <= 1'b1;
        waitEnd();
        check(bootFailed, 1'b1);
        check(stepQ.size(), 9);
        foreach (stepQ[k])
            check(stepQ[k], (k < 5) ? k : k + 1);
        @(posedge clk);
        pinPresent <= 32'hFFFFFFFF;
        magicVal <= MAGIC_WORD;
        boot('{1'b0, 1'b0, 1'b0, 1'b0, '0}, 1'b1);
        waitEnd();
        check(stepQ.size(), 11);
        check(softReset, 1'b1);
        check(remapSel, REMAP_FLASH);
        exp = '{MEM_FLASH_RESET, MEM_FLASH_INIT, MEM_FLASH_INIT, MEM_LOAD_UCODE, MEM_COPY_IMAGE};
        cmpCmds(exp);
        // A host answering at step 0 ends the scan there and the load runs on that link.
        boot('{1'b0, 1'b0, 1'b0, 1'b0, '0}, 1'b0);
        hostSeen <= 1'b1;
        repeat (10) @(posedge clk);
        loadDone <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check(stepQ.size(), 1);
        check(bootIdle, 1'b1);
        check(bootFailed, 1'b0);
        check(softReset, 1'b0);
        boot('{1'b0, 1'b0, 1'b0, 1'b1, '{IF_UART, P1_2, P1_4, 5'h00, 5'h00, DIV_UART_SLOW}}, 1'b0);
        repeat (3 * STEP_TO) @(posedge clk);
        #1;
        check(stepQ.size(), 1);
        check(linkEnable, 1'b1);
        check(linkCfg, hdr.fixedLink);
        @(posedge clk);
        hostSeen <= 1'b1;
        repeat (10) @(posedge clk);
        loadDone <= 1'b1;
        for (int n = 0; n < 50 && bootIdle !== 1'b1; n++)
            @(posedge clk);
        #1;
        check(bootIdle, 1'b1);
        check(bootFailed, 1'b0);
        closeOut();
    end
endmodule
